// ===== verilog/hostbus_pkg.sv
// Shared constants, types and decode helpers of the graphics host port.
package hostbus_pkg;

	// ------------------------------------------------------------------
	// Widths and sizes
	// ------------------------------------------------------------------
	localparam int AW = 20;          // Host address width.
	localparam int DW = 16;          // Host data width.
	localparam int MAW = 18;         // Word address width of one plane.
	localparam int CUR_W = 32;       // Pointer box width in pixels.
	localparam int CUR_H = 512;      // Pointer box height in pixels.
	localparam logic [1:0] STRAP_WAIT = 2'h3; // Cycles before strap capture.

	// ------------------------------------------------------------------
	// APB register offsets and field positions
	// ------------------------------------------------------------------
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_KEY = 8'h04;
	localparam logic [7:0] OFS_MODE = 8'h08;
	localparam logic [7:0] OFS_CPOS = 8'h0c;
	localparam logic [7:0] OFS_CIDX = 8'h10;
	localparam logic [7:0] OFS_CAND = 8'h14;
	localparam logic [7:0] OFS_CXOR = 8'h18;
	localparam logic [7:0] OFS_STAT = 8'h1c;
	localparam logic [7:0] OFS_LATCH = 8'h20;
	localparam int CPOS_Y_LSB = 16;  // Pointer row field starts here.

	// ------------------------------------------------------------------
	// Host decode constants
	// ------------------------------------------------------------------
	localparam logic [9:0] IO_ATTR = 10'h3c0;
	localparam logic [9:0] IO_SEQ = 10'h3c4;
	localparam logic [9:0] IO_GC = 10'h3ce;
	localparam logic [9:0] IO_CRTC = 10'h3d4;
	localparam logic [9:0] IO_CRTM = 10'h3b4;
	localparam logic [9:0] IO_PAL_LO = 10'h3c6;
	localparam logic [9:0] IO_PAL_HI = 10'h3c9;
	localparam logic [9:0] IO_STAT_C = 10'h3da;
	localparam logic [9:0] IO_STAT_M = 10'h3ba;
	localparam logic [19:0] ROM_LO = 20'hc0000;
	localparam logic [19:0] ROM_HI = 20'hc7fff;
	localparam logic [19:0] WIN_LO = 20'ha0000;
	localparam logic [19:0] WIN_HI = 20'hbffff;

	// ------------------------------------------------------------------
	// Types
	// ------------------------------------------------------------------
	typedef enum logic [1:0] {
		PM_PLANAR = 2'h0, PM_CHAIN2 = 2'h1, PM_CHAIN4 = 2'h2
	} plane_mode_t;
	typedef enum logic [1:0] {
		SZ_256K = 2'h0, SZ_512K = 2'h1, SZ_1M = 2'h2
	} mem_size_t;
	typedef enum logic [1:0] {
		S_IDLE = 2'b00, S_BUSY = 2'b01, S_HOLD = 2'b11, S_WORD2 = 2'b10
	} host_state_t;
	typedef struct packed {
		logic ext_en_a;
		logic en16_io;
		logic en16_mem;
	} ctrl_t;
	typedef struct packed {
		logic [3:0] plane_mask;
		logic [3:0] bank;
		mem_size_t size;
		plane_mode_t mode;
	} mode_t;
	typedef struct packed {
		logic [MAW-1:0] addr;
		logic [3:0] planes;
		logic we;
		logic [DW-1:0] wdata;
	} mem_req_t;
	typedef struct packed {
		logic mclk;
		logic ior_n;
		logic iow_n;
		logic memr_n;
		logic memw_n;
		logic bhe_n;
		logic [AW-1:0] addr;
		logic [DW-1:0] data;
		logic strap;
	} pins_t;

	// True when the port is either byte of an index/data pair.
	function automatic logic pair_hit(input logic [9:0] a);
		pair_hit = (a[9:1] == IO_ATTR[9:1]) || (a[9:1] == IO_SEQ[9:1]) ||
			(a[9:1] == IO_GC[9:1]) || (a[9:1] == IO_CRTC[9:1]) ||
			(a[9:1] == IO_CRTM[9:1]);
	endfunction

	// Index of the pair for the local index shadow.
	function automatic logic [2:0] pair_sel(input logic [9:0] a);
		pair_sel = (a[9:1] == IO_ATTR[9:1]) ? 3'h0 :
			(a[9:1] == IO_SEQ[9:1]) ? 3'h1 :
			(a[9:1] == IO_GC[9:1]) ? 3'h2 :
			(a[9:1] == IO_CRTC[9:1]) ? 3'h3 : 3'h4;
	endfunction

endpackage

// ===== verilog/pin_sync.sv
// Three-stage pin synchroniser that accepts a change once stages agree.
`timescale 1ns/100ps
module pin_sync import hostbus_pkg::*; #(
	parameter int W = 1
) (
	// Clock and reset.
	input wire logic clk,
	input wire logic rst,
	// Raw pin levels and the filtered result.
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	logic [W-1:0] s1_r, s2_r, s3_r, q_r; // Stages and filtered level.
	logic [W-1:0] q_nxt;

	// A bit only moves when the second and third stages agree.
	always_comb begin
		q_nxt = (s2_r & s3_r) | (q_r & (s2_r | s3_r));
	end

	// Stage one feeds stage two and nothing else.
	always_ff @(posedge clk) begin
		if (rst) begin
			s1_r <= '0;
			s2_r <= '0;
			s3_r <= '0;
			q_r <= '0;
		end else begin
			s1_r <= d;
			s2_r <= s1_r;
			s3_r <= s2_r;
			q_r <= q_nxt;
		end
	end

	assign q = q_r;
endmodule // pin_sync

// ===== verilog/mem_arbiter.sv
// Slot arbiter sharing display memory between refresh fetch and host.
`timescale 1ns/100ps
module mem_arbiter import hostbus_pkg::*; #(
	parameter int MAX_DISP = 3 // Display slots in a row before host wins.
) (
	// Clock and reset.
	input wire logic clk,
	input wire logic rst,
	// One pulse per memory clock period.
	input wire logic mtick,
	// Requesters.
	input wire logic disp_req,
	input wire logic host_req,
	// Grants, one cycle each.
	output logic disp_gnt,
	output logic host_gnt
);
	logic [1:0] run_r, run_nxt;     // Display slots granted in a row.
	logic dg_r, dg_nxt, hg_r, hg_nxt;
	logic host_turn;

	// Display wins unless it has hogged the memory; an idle host costs it
	// nothing, so the host waits only for slots really in use.
	always_comb begin
		host_turn = host_req && (!disp_req || run_r == 2'(MAX_DISP));
		dg_nxt = 1'b0;
		hg_nxt = 1'b0;
		run_nxt = run_r;
		if (mtick) begin
			if (host_turn) begin
				hg_nxt = 1'b1;
				run_nxt = 2'h0;
			end else if (disp_req) begin
				dg_nxt = 1'b1;
				run_nxt = (run_r == 2'(MAX_DISP)) ? run_r : run_r + 2'h1;
			end
		end
	end

	// Grant registers.
	always_ff @(posedge clk) begin
		if (rst) begin
			run_r <= 2'h0;
			dg_r <= 1'b0;
			hg_r <= 1'b0;
		end else begin
			run_r <= run_nxt;
			dg_r <= dg_nxt;
			hg_r <= hg_nxt;
		end
	end

	assign disp_gnt = dg_r;
	assign host_gnt = hg_r;
endmodule // mem_arbiter

// ===== verilog/gfx_host_port.sv
// Host bus interface of the graphics controller, with APB setup port.
`timescale 1ns/100ps
module gfx_host_port import hostbus_pkg::*; (
	// Clock and reset.
	input wire logic CORE_CLK,
	input wire logic RST,
	// APB slave.
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [7:0] PADDR,
	input wire logic [31:0] PWDATA,
	output logic [31:0] PRDATA,
	output logic PREADY,
	output logic PSLVERR,
	// Host bus pins and personality strap.
	input wire pins_t HOST_PINS,
	output logic [DW-1:0] HOST_DOUT,
	output logic HOST_DOE_N,
	output logic PC_RDY,
	output logic PC_IO16_N,
	output logic PC_MEM16_N,
	output logic ALT_CHRDY,
	output logic ALT_DS16_N,
	output logic BIOS_ROM_SELECT_N,
	// External palette strobes.
	output logic PAL_RD_N,
	output logic PAL_WR_N,
	// Standard register file port.
	output logic [9:0] STD_ADDR,
	output logic STD_WE,
	output logic [7:0] STD_WDATA,
	input wire logic [7:0] STD_RDATA,
	input wire logic [31:0] GC_LATCH,
	// Display memory.
	input wire logic DISP_REQ,
	output logic DISP_GNT,
	output logic MEM_REQ,
	output mem_req_t MEM_CMD,
	input wire logic [DW-1:0] MEM_RDATA,
	// Pointer overlay.
	input wire logic [10:0] PIX_X,
	input wire logic [9:0] PIX_Y,
	output logic CUR_SHOW,
	output logic CUR_INV
);
	// ------------------------------------------------------------------
	// Pin synchronisation and memory clock ticks
	// ------------------------------------------------------------------
	pins_t p; // Filtered pins.
	pin_sync #(.W($bits(pins_t))) u_sync (
		.clk(CORE_CLK), .rst(RST), .d(HOST_PINS), .q(p)
	);
	logic mclk_d_r, mtick, host_gnt;
	logic io_act, mem_act, any_act, pal_hit, rom_hit, win_hit;
	logic [9:0] port;

	// Host strobes and address classes.
	always_comb begin
		port = p.addr[9:0];
		io_act = !p.ior_n || !p.iow_n;
		win_hit = p.addr >= WIN_LO && p.addr <= WIN_HI;
		// Only the display window is ours; ROM and system memory cycles
		// must never see ready pulled low or our data drivers enabled.
		mem_act = (!p.memr_n || !p.memw_n) && win_hit;
		any_act = io_act || mem_act;
		pal_hit = port >= IO_PAL_LO && port <= IO_PAL_HI;
		rom_hit = p.addr >= ROM_LO && p.addr <= ROM_HI;
		mtick = p.mclk && !mclk_d_r;
	end

	// ------------------------------------------------------------------
	// Registers and APB slave
	// ------------------------------------------------------------------
	ctrl_t ctrl_r, ctrl_nxt;     // 16-bit enables and first key.
	mode_t mode_r, mode_nxt;     // Extended memory mapping.
	logic key_r, key_nxt;        // Second extended enable.
	logic [10:0] cx_r, cx_nxt;   // Pointer column.
	logic [9:0] cy_r, cy_nxt;    // Pointer row.
	logic [8:0] cidx_r, cidx_nxt; // Pointer shape row index.
	logic [31:0] cand_r, cand_nxt; // Pending AND row.
	logic [31:0] prd_r, prd_nxt;
	logic err_r, err_nxt, ext_ok, setup, wr_acc, shape_we;
	logic alt_r, alt_nxt, attr_ff_r, attr_ff_nxt;
	logic [1:0] cap_r, cap_nxt;  // Strap capture delay.
	host_state_t st_r, st_nxt;
	logic [31:0] shape_and [CUR_H];
	logic [31:0] shape_xor [CUR_H];

	// Reads are prepared in the setup phase so PRDATA comes from a flop
	// and the slave answers with no wait state.
	always_comb begin
		ext_ok = ctrl_r.ext_en_a && key_r;
		setup = PSEL && !PENABLE;
		wr_acc = PSEL && PENABLE && PWRITE;
		ctrl_nxt = ctrl_r;
		key_nxt = key_r;
		mode_nxt = mode_r;
		cx_nxt = cx_r;
		cy_nxt = cy_r;
		cidx_nxt = cidx_r;
		cand_nxt = cand_r;
		shape_we = 1'b0;
		prd_nxt = prd_r;
		err_nxt = err_r;
		if (setup) begin
			err_nxt = 1'b0;
			case (PADDR)
				OFS_CTRL: prd_nxt = 32'(ctrl_r);
				OFS_KEY: prd_nxt = 32'(key_r);
				OFS_MODE: prd_nxt = 32'(mode_r);
				OFS_CPOS: prd_nxt = (32'(cy_r) << CPOS_Y_LSB) | 32'(cx_r);
				OFS_CIDX: prd_nxt = 32'(cidx_r);
				OFS_CAND: prd_nxt = cand_r;
				OFS_CXOR: prd_nxt = 32'h0;
				OFS_STAT: prd_nxt = {28'h0, st_r, attr_ff_r, alt_r};
				OFS_LATCH: prd_nxt = GC_LATCH;
				default: begin
					prd_nxt = 32'h0;
					err_nxt = 1'b1;
				end
			endcase
		end
		if (wr_acc) begin
			case (PADDR)
				OFS_CTRL: ctrl_nxt = ctrl_t'(PWDATA[2:0]);
				OFS_KEY: key_nxt = PWDATA[0];
				default: begin
				end
			endcase
			if (ext_ok) begin
				case (PADDR)
					OFS_MODE: mode_nxt = mode_t'(PWDATA[11:0]);
					OFS_CPOS: begin
						cx_nxt = PWDATA[10:0];
						cy_nxt = PWDATA[CPOS_Y_LSB +: 10];
					end
					OFS_CIDX: cidx_nxt = PWDATA[8:0];
					OFS_CAND: cand_nxt = PWDATA;
					OFS_CXOR: begin
						shape_we = 1'b1;
						cidx_nxt = cidx_r + 9'h1;
					end
					default: begin
					end
				endcase
			end
		end
	end

	// Strap is caught on the third clock after reset, a cycle before the filter passes it, so alt_r always loads 0.
	always_comb begin
		cap_nxt = (cap_r == STRAP_WAIT) ? cap_r : cap_r + 2'h1;
		alt_nxt = (cap_r == STRAP_WAIT - 2'h1) ? p.strap : alt_r;
	end

	// Register state; reset leaves every cycle byte wide.
	always_ff @(posedge CORE_CLK) begin
		if (RST) begin
			ctrl_r <= '0;
			key_r <= 1'b0;
			mode_r <= '0;
			cx_r <= '0;
			cy_r <= '0;
			cidx_r <= '0;
			cand_r <= '1;
			prd_r <= '0;
			err_r <= 1'b0;
			cap_r <= 2'h0;
			alt_r <= 1'b0;
			mclk_d_r <= 1'b0;
		end else begin
			ctrl_r <= ctrl_nxt;
			key_r <= key_nxt;
			mode_r <= mode_nxt;
			cx_r <= cx_nxt;
			cy_r <= cy_nxt;
			cidx_r <= cidx_nxt;
			cand_r <= cand_nxt;
			prd_r <= prd_nxt;
			err_r <= err_nxt;
			cap_r <= cap_nxt;
			alt_r <= alt_nxt;
			mclk_d_r <= p.mclk;
		end
	end

	// Shape rows carry no reset; software loads them before use.
	always_ff @(posedge CORE_CLK) begin
		if (shape_we) begin
			shape_and[cidx_r] <= cand_r;
			shape_xor[cidx_r] <= PWDATA;
		end
	end

	assign PRDATA = prd_r;
	assign PREADY = 1'b1;
	assign PSLVERR = err_r && PSEL && PENABLE;

	// ------------------------------------------------------------------
	// Host cycle engine
	// ------------------------------------------------------------------
	logic [7:0] idx_r [5];       // Index shadow per pair.
	logic [7:0] idx_nxt [5];
	logic [DW-1:0] dout_r, dout_nxt, hi_r, hi_nxt;
	logic [9:0] sa_r, sa_nxt;
	logic we_r, we_nxt, io16_n_r, io16_n_nxt, m16_n_r, m16_n_nxt;
	logic rom_n_r, rom_n_nxt, prd_n_r, prd_n_nxt, pwr_n_r, pwr_n_nxt;
	logic [7:0] sw_r, sw_nxt;
	logic io_wide, mem_wide, hreq_r, hreq_nxt, rdy;
	mem_req_t cmd_r, cmd_nxt;
	logic [19:0] off;
	logic [MAW-1:0] amask;

	// Memory address mapping for the three plane modes.
	always_comb begin
		off = {mode_r.bank, p.addr[15:0]};
		case (mode_r.size)
			SZ_256K: amask = 18'h0ffff;
			SZ_512K: amask = 18'h1ffff;
			default: amask = 18'h3ffff;
		endcase
		cmd_nxt = cmd_r;
		case (mode_r.mode)
			PM_CHAIN2: begin
				cmd_nxt.addr = off[18:1] & amask;
				cmd_nxt.planes = off[0] ? 4'ha : 4'h5;
			end
			PM_CHAIN4: begin
				cmd_nxt.addr = off[19:2] & amask;
				cmd_nxt.planes = 4'h1 << off[1:0];
			end
			default: begin
				cmd_nxt.addr = off[17:0] & amask;
				cmd_nxt.planes = mode_r.plane_mask;
			end
		endcase
		cmd_nxt.we = !p.memw_n;
		cmd_nxt.wdata = p.data;
	end

	// The cycle starts in IDLE; I/O never leaves ready low.
	always_comb begin
		io_wide = ctrl_r.en16_io && pair_hit(port) && !p.bhe_n &&
			!port[0];
		mem_wide = ctrl_r.en16_mem && win_hit;
		st_nxt = st_r;
		dout_nxt = dout_r;
		hi_nxt = hi_r;
		sa_nxt = sa_r;
		sw_nxt = sw_r;
		we_nxt = 1'b0;
		hreq_nxt = hreq_r;
		attr_ff_nxt = attr_ff_r;
		for (int i = 0; i < 5; i++) begin
			idx_nxt[i] = idx_r[i];
		end
		case (st_r)
			S_IDLE: begin
				sa_nxt = io_wide ? (port | 10'h1) : port;
				if (io_act) begin
					st_nxt = S_HOLD;
					if (!p.iow_n && !pal_hit) begin
						we_nxt = 1'b1;
						sa_nxt = port;
						sw_nxt = (port[0] && !p.bhe_n) ?
							p.data[15:8] : p.data[7:0];
						hi_nxt = p.data;
						if (io_wide) begin
							st_nxt = S_WORD2;
						end
						if (pair_hit(port) && !port[0]) begin
							idx_nxt[pair_sel(port)] = p.data[7:0];
						end
						if (port == IO_ATTR) begin
							attr_ff_nxt = !attr_ff_r;
						end
					end else if (!p.ior_n) begin
						dout_nxt = io_wide ?
							{STD_RDATA, idx_r[pair_sel(port)]} :
							{STD_RDATA, STD_RDATA};
						if (port == IO_STAT_C || port == IO_STAT_M) begin
							attr_ff_nxt = 1'b0;
						end
					end
				end else if (mem_act) begin
					st_nxt = S_BUSY;
					hreq_nxt = 1'b1;
				end
			end
			S_WORD2: begin
				we_nxt = 1'b1;
				sa_nxt = sa_r | 10'h1;
				sw_nxt = hi_r[15:8];
				attr_ff_nxt = (sa_r == IO_ATTR) ? !attr_ff_r : attr_ff_r;
				st_nxt = S_HOLD;
			end
			S_BUSY: begin
				if (host_gnt) begin
					hreq_nxt = 1'b0;
					dout_nxt = MEM_RDATA;
					st_nxt = S_HOLD;
				end
			end
			S_HOLD: begin
				if (!any_act) begin
					st_nxt = S_IDLE;
				end
			end
			default: st_nxt = S_IDLE;
		endcase
		rdy = !(mem_act && (st_r == S_IDLE || st_r == S_BUSY));
		io16_n_nxt = !(ctrl_r.en16_io && pair_hit(port));
		m16_n_nxt = !mem_wide;
		rom_n_nxt = !(!alt_r && !p.memr_n && rom_hit);
		prd_n_nxt = !(!p.ior_n && pal_hit);
		pwr_n_nxt = !(!p.iow_n && pal_hit);
	end

	// Host engine state.
	always_ff @(posedge CORE_CLK) begin
		if (RST) begin
			st_r <= S_IDLE;
			dout_r <= '0;
			hi_r <= '0;
			sa_r <= '0;
			sw_r <= '0;
			we_r <= 1'b0;
			hreq_r <= 1'b0;
			attr_ff_r <= 1'b0;
			cmd_r <= '0;
			io16_n_r <= 1'b1;
			m16_n_r <= 1'b1;
			rom_n_r <= 1'b1;
			prd_n_r <= 1'b1;
			pwr_n_r <= 1'b1;
			for (int i = 0; i < 5; i++) begin
				idx_r[i] <= '0;
			end
		end else begin
			st_r <= st_nxt;
			dout_r <= dout_nxt;
			hi_r <= hi_nxt;
			sa_r <= sa_nxt;
			sw_r <= sw_nxt;
			we_r <= we_nxt;
			hreq_r <= hreq_nxt;
			attr_ff_r <= attr_ff_nxt;
			cmd_r <= (st_r == S_IDLE) ? cmd_nxt : cmd_r;
			io16_n_r <= io16_n_nxt;
			m16_n_r <= m16_n_nxt;
			rom_n_r <= rom_n_nxt;
			prd_n_r <= prd_n_nxt;
			pwr_n_r <= pwr_n_nxt;
			idx_r <= idx_nxt;
		end
	end

	mem_arbiter u_arb (
		.clk(CORE_CLK), .rst(RST), .mtick(mtick), .disp_req(DISP_REQ),
		.host_req(hreq_r), .disp_gnt(DISP_GNT), .host_gnt(host_gnt)
	);

	// Each personality drives only its own handshake pins.
	assign PC_RDY = alt_r ? 1'b1 : rdy;
	assign ALT_CHRDY = alt_r ? rdy : 1'b1;
	assign PC_IO16_N = alt_r ? 1'b1 : (io16_n_r && m16_n_r);
	assign PC_MEM16_N = alt_r ? 1'b1 : m16_n_r;
	assign ALT_DS16_N = alt_r ? (io16_n_r && m16_n_r) : 1'b1;
	assign BIOS_ROM_SELECT_N = rom_n_r;
	assign HOST_DOUT = dout_r;
	// The external palette drives its own read data.
	assign HOST_DOE_N = !(st_r == S_HOLD &&
		(!p.memr_n || (!p.ior_n && !pal_hit)));
	assign PAL_RD_N = prd_n_r;
	assign PAL_WR_N = pwr_n_r;
	assign STD_ADDR = sa_r;
	assign STD_WE = we_r;
	assign STD_WDATA = sw_r;
	assign MEM_REQ = host_gnt;
	assign MEM_CMD = cmd_r;

	// ------------------------------------------------------------------
	// Pointer overlay
	// ------------------------------------------------------------------
	logic [10:0] dx;
	logic [9:0] dy;
	logic inbox, a_bit, x_bit, show_r, inv_r;

	// AND=1,XOR=0 is transparent; AND=0 paints; AND=1,XOR=1 inverts.
	always_comb begin
		dx = PIX_X - cx_r;
		dy = PIX_Y - cy_r;
		inbox = PIX_X >= cx_r && dx < 11'(CUR_W) && PIX_Y >= cy_r &&
			dy < 10'(CUR_H);
		a_bit = shape_and[dy[8:0]][dx[4:0]];
		x_bit = shape_xor[dy[8:0]][dx[4:0]];
	end

	// Overlay outputs registered.
	always_ff @(posedge CORE_CLK) begin
		if (RST) begin
			show_r <= 1'b0;
			inv_r <= 1'b0;
		end else begin
			show_r <= inbox && !a_bit;
			inv_r <= inbox && a_bit && x_bit;
		end
	end

	assign CUR_SHOW = show_r;
	assign CUR_INV = inv_r;

	// ------------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------------
	a_io_nowait: assert property (@(posedge CORE_CLK) disable iff (RST)
		io_act && !mem_act |-> rdy) else $error("io cycle waited");
	a_reset_byte: assert property (@(posedge CORE_CLK)
		RST ##1 !RST |-> !ctrl_r.en16_io && !ctrl_r.en16_mem)
		else $error("16-bit enabled after reset");
	a_ext_gate: assert property (@(posedge CORE_CLK) disable iff (RST)
		wr_acc && PADDR == OFS_MODE && !ext_ok |=> $stable(mode_r))
		else $error("extended write not ignored");
	a_word_split: assert property (@(posedge CORE_CLK) disable iff (RST)
		st_r == S_WORD2 |-> we_r && !sa_r[0] ##1 we_r && sa_r[0])
		else $error("word write not split index then data");
	a_io16_pair: assert property (@(posedge CORE_CLK) disable iff (RST)
		!io16_n_r |-> $past(ctrl_r.en16_io && pair_hit(port)))
		else $error("16-bit io outside pairs");
	a_rom_pc: assert property (@(posedge CORE_CLK) disable iff (RST)
		!rom_n_r |-> $past(!alt_r && rom_hit && !p.memr_n))
		else $error("rom select misdecoded");
	a_pal_write: assert property (@(posedge CORE_CLK) disable iff (RST)
		!pwr_n_r |-> $past(pal_hit && !p.iow_n) && !we_r)
		else $error("palette strobe misdecoded");
	a_mem_grant: assert property (@(posedge CORE_CLK) disable iff (RST)
		hreq_r && mtick && !DISP_REQ |=> host_gnt)
		else $error("host waited on idle memory");
	a_strap_hold: assert property (@(posedge CORE_CLK) disable iff (RST)
		cap_r == STRAP_WAIT |=> $stable(alt_r))
		else $error("personality changed after capture");
endmodule // gfx_host_port

// ===== sim/host_cpu_model.sv
// Behavioural host processor that drives the port's bus pins.
`timescale 1ns/100ps
module host_cpu_model import hostbus_pkg::*; (
	// Bus clock.
	input wire logic clk,
	// Pins toward the port.
	output wire pins_t pins
);
	pins_t bus; // Strobes, address, data and strap.
	logic mclk; // Memory clock, free running and unrelated to clk.
	assign pins = {mclk, bus[41:0]};
	// Idle bus; the strap stays low from reset on, so PC personality.
	initial begin
		mclk = 1'b0;
		bus = '1;
		bus.strap = 1'b0;
	end
	always #20 mclk = ~mclk;
	// Opens a cycle: kind 0 io read, 1 io write, 2 mem read, 3 mem write.
	task start(input logic [1:0] k, input logic [19:0] a,
		input logic [15:0] d, input logic bh);
		@(posedge clk);
		bus.addr <= a;
		bus.data <= d;
		bus.bhe_n <= bh;
		bus.ior_n <= (k != 2'h0);
		bus.iow_n <= (k != 2'h1);
		bus.memr_n <= (k != 2'h2);
		bus.memw_n <= (k != 2'h3);
	endtask
	// Ends a cycle; the released data bus shows the inverse of its last
	// value, so stale data can never pass for fresh data.
	task stop();
		@(posedge clk);
		bus.ior_n <= 1'b1;
		bus.iow_n <= 1'b1;
		bus.memr_n <= 1'b1;
		bus.memw_n <= 1'b1;
		bus.data <= ~bus.data;
	endtask
endmodule // host_cpu_model

// ===== sim/graphics_host_bus_interface_tb.sv
// Self-checking bench of the graphics host port.
`timescale 1ns/100ps
module graphics_host_bus_interface_tb;
	import hostbus_pkg::*;
	// ------------------------------------------------------------
	// Signals
	// ------------------------------------------------------------
	logic clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0;
	logic pwrite = 1'b0, pready, pslverr, rdy, alt_rdy, io16_n, m16_n;
	logic rom_n, prd_n, pwr_n, we, dreq = 1'b0, mreq;
	logic [7:0] paddr = '0, wd;
	logic [31:0] pwdata = '0, prdata;
	logic [9:0] sa;
	logic [15:0] dout;
	logic doe_n, show, inv;
	logic [10:0] pix_x = '0;
	logic [9:0] pix_y = '0;
	logic [15:0] lfsr = 16'ha066; // Random source, fixed start.
	logic [32:0] apb_q[$]; // Expected {slverr, rdata} of reads.
	logic [17:0] std_q[$]; // Expected {addr, data} of register writes.
	pins_t pins;
	int err_count = 0, num_checks = 0, cyc = 0, mwait = 0, nreq = 0;
	always #2.5 clk = ~clk;
	gfx_host_port gfx_host_port_inst (.CORE_CLK(clk), .RST(rst),
		.PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
		.PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
		.PSLVERR(pslverr), .HOST_PINS(pins), .HOST_DOUT(dout),
		.HOST_DOE_N(doe_n), .PC_RDY(rdy), .PC_IO16_N(io16_n),
		.PC_MEM16_N(m16_n), .ALT_CHRDY(alt_rdy), .ALT_DS16_N(),
		.BIOS_ROM_SELECT_N(rom_n), .PAL_RD_N(prd_n), .PAL_WR_N(pwr_n),
		.STD_ADDR(sa), .STD_WE(we), .STD_WDATA(wd),
		.STD_RDATA(8'h5a), .GC_LATCH(32'h1234abcd), .DISP_REQ(dreq),
		.DISP_GNT(), .MEM_REQ(mreq), .MEM_CMD(), .MEM_RDATA(lfsr),
		.PIX_X(pix_x), .PIX_Y(pix_y), .CUR_SHOW(show), .CUR_INV(inv));
	host_cpu_model host_cpu_model_inst (.clk(clk), .pins(pins));
	// ------------------------------------------------------------
	// Compare, report and drive tasks
	// ------------------------------------------------------------
	task cmp_apb(input logic [32:0] e, input logic [32:0] s);
		num_checks++;
		if (s !== e) begin
			err_count++;
			$display("[FAIL] apb read exp %h got %h", e, s);
		end
	endtask
	task cmp_std(input logic [17:0] e, input logic [17:0] s);
		num_checks++;
		if (s !== e) begin
			err_count++;
			$display("[FAIL] std write exp %h got %h", e, s);
		end
	endtask
	task cmp_dat(input string n, input logic [15:0] e,
		input logic [15:0] s);
		num_checks++;
		if (s !== e) begin
			err_count++;
			$display("[FAIL] %s exp %h got %h", n, e, s);
		end
	endtask
	task cmp_pin(input string n, input logic e, input logic s);
		num_checks++;
		if (s !== e) begin
			err_count++;
			$display("[FAIL] %s exp %b got %b", n, e, s);
		end
	endtask
	task finish_test();
		if (apb_q.size() || std_q.size()) err_count++;
		$display("checks %0d errors %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	// One step of the 16-bit random source.
	function automatic logic [15:0] lfsr_step(input logic [15:0] v);
		return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
	endfunction
	// One APB transfer; a read notes its expected answer first.
	task apb(input logic w, input logic [7:0] a, input logic [32:0] x);
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= x[31:0];
		if (!w) apb_q.push_back(x);
		@(posedge clk);
		penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// Host io write; word transfers become index then data writes.
	task io_wr(input logic [9:0] a, input logic bh, input logic w16);
		logic [15:0] r;
		r = lfsr_step(lfsr);
		lfsr <= r;
		if (w16) begin
			std_q.push_back({a, r[7:0]});
			std_q.push_back({a | 10'h1, r[15:8]});
		end else
			std_q.push_back({a, (a[0] && !bh) ? r[15:8] : r[7:0]});
		host_cpu_model_inst.start(2'h1, {10'h0, a}, r, bh);
		repeat (8) @(posedge clk);
		if (!a[0]) cmp_pin("io16_n", !w16, io16_n);
		host_cpu_model_inst.stop();
		repeat (8) @(posedge clk);
	endtask
	// Host io read; the answer stands on the data pins until release.
	task io_rd(input logic [9:0] a, input logic bh, input logic [15:0] e);
		host_cpu_model_inst.start(2'h0, {10'h0, a}, '0, bh);
		repeat (8) @(posedge clk);
		cmp_dat("io rdata", e, dout);
		cmp_pin("io doe_n", 1'b0, doe_n);
		host_cpu_model_inst.stop();
		repeat (8) @(posedge clk);
	endtask
	// ------------------------------------------------------------
	// Monitors: results are matched against the oldest note.
	// ------------------------------------------------------------
	always @(posedge clk) begin
		cyc++;
		if (psel && penable && pready === 1'b1 && !pwrite)
			cmp_apb(apb_q.size() ? apb_q.pop_front() : 'x, {pslverr, prdata});
		if (we === 1'b1)
			cmp_std(std_q.size() ? std_q.pop_front() : 'x, {sa, wd});
		if (!pins.ior_n || !pins.iow_n) cmp_pin("io rdy", 1'b1, rdy);
		if (rdy === 1'b0) mwait++;
		if (mreq === 1'b1) nreq++;
		if (cyc == 20000) begin
			err_count++;
			finish_test();
		end
	end
	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		repeat (16) @(posedge clk);
		rst <= 1'b0;
		repeat (8) @(posedge clk);
		apb(1'b0, OFS_CTRL, 33'h0);
		apb(1'b0, OFS_STAT, 33'h0);
		apb(1'b0, 8'hfc, {1'b1, 32'h0});
		cmp_pin("alt_rdy", 1'b1, alt_rdy);
		// Mode writes are dropped until both enables are set.
		apb(1'b1, OFS_MODE, {21'h0, lfsr[11:4], 4'h6});
		apb(1'b1, OFS_CTRL, 33'h4);
		apb(1'b0, OFS_MODE, 33'h0);
		apb(1'b1, OFS_KEY, 33'h1);
		apb(1'b1, OFS_MODE, {21'h0, lfsr[11:4], 4'h6});
		apb(1'b0, OFS_MODE, {21'h0, lfsr[11:4], 4'h6});
		apb(1'b0, OFS_LATCH, {1'b0, 32'h1234abcd});
		// Pointer row 0: bit 0 paints, bit 1 inverts, the rest is clear.
		apb(1'b1, OFS_CPOS, 33'h0);
		apb(1'b1, OFS_CIDX, 33'h0);
		apb(1'b1, OFS_CAND, 33'hfffffffe);
		apb(1'b1, OFS_CXOR, 33'h2);
		for (int k = 0; k < 3; k++) begin
			pix_x <= (k == 2) ? 11'h28 : 11'(k);
			repeat (2) @(posedge clk);
			cmp_pin("cur_show", k == 0, show);
			cmp_pin("cur_inv", k == 1, inv);
		end
		io_wr(IO_SEQ, 1'b0, 1'b0);
		apb(1'b1, OFS_CTRL, 33'h6);
		io_wr(IO_SEQ, 1'b0, 1'b1);
		io_wr(IO_CRTC, 1'b0, 1'b1);
		io_rd(IO_CRTC, 1'b0, {8'h5a, lfsr[7:0]});
		io_wr(10'h3c2, 1'b0, 1'b0);
		io_rd(10'h3c2, 1'b0, 16'h5a5a);
		io_wr(IO_GC | 10'h1, 1'b0, 1'b0);
		// Palette reads and writes each strobe their own line.
		for (int k = 0; k < 2; k++) begin
			host_cpu_model_inst.start(k[1:0], {10'h0, IO_PAL_LO}, '0, 1'b1);
			repeat (8) @(posedge clk);
			cmp_pin("pal", 1'b0, k ? pwr_n : prd_n);
			cmp_pin("pal doe_n", 1'b1, doe_n);
			host_cpu_model_inst.stop();
			repeat (8) @(posedge clk);
			cmp_pin("pal", 1'b1, k ? pwr_n : prd_n);
		end
		// Window read against busy display traffic, then a ROM read.
		dreq <= 1'b1;
		mwait = 0;
		host_cpu_model_inst.start(2'h2, WIN_LO, '0, 1'b1);
		repeat (80) @(posedge clk);
		cmp_pin("mem16_n", 1'b1, m16_n);
		cmp_pin("rom_n", 1'b1, rom_n);
		cmp_pin("wait", 1'b1, mwait > 0 && mwait <= 40 && nreq == 1);
		cmp_dat("mem rdata", lfsr, dout);
		host_cpu_model_inst.stop();
		repeat (8) @(posedge clk);
		host_cpu_model_inst.start(2'h2, ROM_LO + 20'h4000, '0, 1'b1);
		repeat (8) @(posedge clk);
		cmp_pin("rom_n", 1'b0, rom_n);
		cmp_pin("rom doe_n", 1'b1, doe_n);
		host_cpu_model_inst.stop();
		repeat (8) @(posedge clk);
		cmp_pin("rom_n", 1'b1, rom_n);
		finish_test();
	end
endmodule // graphics_host_bus_interface_tb
